/* include/flags_pkg.sv */
// package: condition-flag register layout, bus map and instruction classes
package flags_pkg;

	// ----------------------------------------
	// register map (word addresses on the bus)
	// ----------------------------------------
	localparam logic [1:0] FLAGS_ADDR = 2'h0; // cpu_condition_flags
	localparam logic [1:0] ALU_RES_ADDR = 2'h1; // last alu result, read only
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ----------------------------------------
	// bit positions of cpu_condition_flags
	// ----------------------------------------
	localparam int SC_BIT = 7;
	localparam int CZ_BIT = 6;
	localparam int TO_BIT = 5;
	localparam int PD_BIT = 4;
	localparam int OV_BIT = 3;
	localparam int Z_BIT = 2;
	localparam int AC_BIT = 1;
	localparam int C_BIT = 0;

	// software-writable bits: timeout and power-down are read only
	localparam logic [7:0] SW_WRITE_MASK = 8'hCF;
	// reset value: timeout and power-down cleared, others undefined (zero here)
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// ----------------------------------------
	// instruction classes seen by the flag logic
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ADD = 3'h1,
		OP_SUB = 3'h3,
		OP_SUB_BORROW = 3'h2,
		OP_LOGIC = 3'h6
	} op_class_e;

	// one alu update request
	typedef struct packed {
		logic valid;
		op_class_e op;
		logic [7:0] a;
		logic [7:0] b;
		logic carry_in;
	} alu_req_s;

	// control events from the core
	typedef struct packed {
		logic wdt_expire;
		logic watchdog_clear_instr;
		logic halt_instr;
	} ctrl_evt_s;

endpackage : flags_pkg

/* verilog/flag_alu.sv */
// file: 8-bit alu result and raw flag computation
`timescale 1ns/1ps

module flag_alu (
	// operation
	input flags_pkg::alu_req_s req,
	// results
	output logic [7:0] result,
	output logic ov,
	output logic zero,
	output logic aux_carry,
	output logic carry
);
	import flags_pkg::*;

	wire is_sub = (req.op == OP_SUB) || (req.op == OP_SUB_BORROW);
	wire is_sbc = (req.op == OP_SUB_BORROW);
	wire [7:0] b_eff = is_sub ? ~req.b : req.b;
	// subtract: a + ~b + 1, borrow variant uses carry as not-borrow
	wire cin = is_sub ? (is_sbc ? req.carry_in : 1'b1) : (req.op == OP_ADD ? 1'b0 : 1'b0);
	wire [4:0] lo_sum = {1'b0, req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	wire [3:0] hi_low3 = {1'b0, req.a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, lo_sum[4]};
	wire [1:0] top = {1'b0, req.a[7]} + {1'b0, b_eff[7]} + {1'b0, hi_low3[3]};
	wire [7:0] arith = {top[0], hi_low3[2:0], lo_sum[3:0]};
	wire [7:0] logic_res = req.a & req.b;

	// result and flags
	assign result = (req.op == OP_LOGIC) ? logic_res : arith;
	assign ov = hi_low3[3] ^ top[1]; // carry into top bit vs carry out
	assign zero = (result == 8'h00);
	assign aux_carry = lo_sum[4]; // nibble carry, or no nibble borrow on subtract
	assign carry = top[1];

endmodule : flag_alu

/* verilog/cpu_status_flags.sv */
// file: condition-flag register with avalon-mm slave access
`timescale 1ns/1ps

// Contract
// - bit 7 becomes overflow xor result msb after each affecting instruction.
// - subtract instructions copy the zero flag into chained zero, bit 6.
// - subtract-with-borrow ands previous chained zero with current zero result.
// - all other instructions leave chained zero unchanged.
// - timeout bit 5 cleared by reset, watchdog-clear and halt.
// - timeout bit set when watchdog expires.
// - power-down bit 4 cleared by reset or watchdog-clear, set by halt.
// - overflow bit 3 is carry into top bit xor carry out on arithmetic, cleared by logic.
// - zero bit 2 set when result is zero, else cleared.
// - aux carry set on low-nibble carry or no nibble borrow.
// - flags are never pushed automatically on interrupt or call.
module cpu_status_flags (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// alu and control events from the core
	input flags_pkg::alu_req_s alu_req,
	input flags_pkg::ctrl_evt_s ctrl_evt,
	// flag outputs toward the core
	output logic [7:0] flags,
	output logic [7:0] alu_result,
	// avalon-mm slave
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import flags_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] res_q;
	logic [31:0] rdata_q;
	logic ack_q;

	// ----------------------------------------
	// alu
	// ----------------------------------------
	logic [7:0] alu_res;
	logic alu_ov;
	logic alu_z;
	logic alu_ac;
	logic alu_c;

	flag_alu u_alu (
		.req(alu_req),
		.result(alu_res),
		.ov(alu_ov),
		.zero(alu_z),
		.aux_carry(alu_ac),
		.carry(alu_c)
	);

	// ----------------------------------------
	// bus decode: one wait cycle, answer on the second edge
	// ----------------------------------------
	wire bus_req = avs_read | avs_write;
	wire bus_done = bus_req & ack_q;
	wire sw_wr = avs_write & bus_done & (avs_address == FLAGS_ADDR);
	wire alu_upd = alu_req.valid & (alu_req.op != OP_NONE);
	wire is_arith = alu_req.op != OP_LOGIC;
	wire is_sub = alu_req.op == OP_SUB;
	wire is_sbc = alu_req.op == OP_SUB_BORROW;
	wire ov_new = is_arith ? alu_ov : 1'b0;
	wire [31:0] rd_mux = (avs_address == FLAGS_ADDR) ? {24'h000000, flags_q} :
		(avs_address == ALU_RES_ADDR) ? {24'h000000, res_q} : {24'h000000, UNMAPPED_READ};

	// ----------------------------------------
	// next flag value
	// ----------------------------------------
	always_comb begin
		flags_d = flags_q;
		// software write first; hardware updates below take priority
		if (sw_wr) begin
			flags_d = (avs_writedata[7:0] & SW_WRITE_MASK) | (flags_q & ~SW_WRITE_MASK);
		end
		if (alu_upd) begin
			flags_d[Z_BIT] = alu_z;
			flags_d[OV_BIT] = ov_new;
			flags_d[SC_BIT] = ov_new ^ alu_res[7];
			if (is_arith) begin
				flags_d[AC_BIT] = alu_ac;
				flags_d[C_BIT] = alu_c;
			end
			if (is_sub) begin
				flags_d[CZ_BIT] = alu_z;
			end else if (is_sbc) begin
				flags_d[CZ_BIT] = flags_q[CZ_BIT] & alu_z;
			end
			// other classes keep chained zero
		end
		// power-down and timeout; expiry wins over a same-cycle clear
		if (ctrl_evt.watchdog_clear_instr) begin
			flags_d[PD_BIT] = 1'b0;
			flags_d[TO_BIT] = 1'b0;
		end
		if (ctrl_evt.halt_instr) begin
			flags_d[PD_BIT] = 1'b1;
			flags_d[TO_BIT] = 1'b0;
		end
		if (ctrl_evt.wdt_expire) begin
			flags_d[TO_BIT] = 1'b1;
		end
	end

	// ----------------------------------------
	// registers; no save path exists for calls or interrupts
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_q <= FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// last alu result
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			res_q <= 8'h00;
		end else if (alu_upd) begin
			res_q <= alu_res;
		end
	end

	// bus answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req & ~ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// outputs
	assign flags = flags_q;
	assign alu_result = res_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = bus_req & ~ack_q;

endmodule : cpu_status_flags

/* bench/cpu_status_flags_assertions.sv */
// checker: flag register assertions
`timescale 1ns/1ps
module flags_checker (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// core side
	input flags_pkg::alu_req_s alu_req,
	input flags_pkg::ctrl_evt_s ctrl_evt,
	input logic [7:0] flags,
	input logic [7:0] alu_result,
	// bus side
	input wire logic avs_write,
	input logic avs_waitrequest
);
	import flags_pkg::*;
	wire go = alu_req.valid && alu_req.op != OP_NONE;
	wire [2:0] op = alu_req.op;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_wr; avs_write && !avs_waitrequest; endsequence
	a_sc_xor: assert property (go |=> flags[7] == (flags[3] ^ alu_result[7]))
		else $error("sc");
	a_cz_sub: assert property (go && op == OP_SUB |=> flags[6] == flags[2])
		else $error("cz sub");
	a_cz_chain: assert property (go && op == OP_SUB_BORROW |=>
		flags[6] == ($past(flags[6]) & flags[2])) else $error("cz chain");
	a_cz_keep: assert property (!avs_write && !(go && op[2:1] == 2'h1) |=>
		$stable(flags[6])) else $error("cz keep");
	a_to_clear: assert property ((ctrl_evt.halt_instr || ctrl_evt.watchdog_clear_instr) &&
		!ctrl_evt.wdt_expire |=> !flags[5]) else $error("to clear");
	a_to_set: assert property (ctrl_evt.wdt_expire |=> flags[5]) else $error("to set");
	a_pd_halt: assert property (ctrl_evt.halt_instr |=> flags[4]) else $error("pd");
	a_zero_res: assert property (go |=> flags[2] == (alu_result == 8'h00))
		else $error("z");
	a_ov_add: assert property (go && op == OP_ADD |=> flags[3] ==
		(($past(alu_req.a[7]) == $past(alu_req.b[7])) && (alu_result[7] != $past(alu_req.a[7]))))
		else $error("ov add");
	a_ac_add: assert property (go && op == OP_ADD |=> flags[1] ==
		(({1'b0, $past(alu_req.a[3:0])} + {1'b0, $past(alu_req.b[3:0])}) > 5'h0F))
		else $error("ac add");
	a_ro_bits: assert property (s_wr ##0 ctrl_evt == 3'h0 |=> $stable(flags[5:4]))
		else $error("ro");
endmodule : flags_checker
bind cpu_status_flags flags_checker flags_checker_i (.clk(clk), .sys_rst(sys_rst),
	.alu_req(alu_req), .ctrl_evt(ctrl_evt), .flags(flags), .alu_result(alu_result),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

/* bench/cpu_core_model.sv */
// partner: random alu traffic and core events
`timescale 1ns/1ps
module cpu_core_model (
	// clock and enable
	input wire logic clk,
	input wire logic run,
	// toward the flag block
	output flags_pkg::alu_req_s alu_req,
	output flags_pkg::ctrl_evt_s ctrl_evt
);
	import flags_pkg::*;
	op_class_e ops [5] = '{OP_NONE, OP_ADD, OP_SUB, OP_SUB_BORROW, OP_LOGIC};
	op_class_e o;
	logic [7:0] a_v;
	logic [7:0] b_v;
	initial alu_req = '0;
	initial ctrl_evt = '0;
	// valid request on about three cycles in four, equal operands often for zero results
	always @(posedge clk) begin
		o = ops[$urandom % 5];
		a_v = 8'($urandom);
		b_v = ($urandom % 3 == 0) ? a_v : 8'($urandom);
		alu_req <= '{run && $urandom % 4 != 0, o, a_v, b_v, 1'($urandom)};
		ctrl_evt <= run ? ctrl_evt_s'(3'($urandom & $urandom & $urandom)) : '0;
	end
endmodule : cpu_core_model

/* bench/cpu_status_flags_tb.sv */
// testbench: flag register against a reference model
`timescale 1ns/1ps
module cpu_status_flags_tb;
	import flags_pkg::*;
	logic clk = 0, sys_rst = 1, run = 0, avs_read = 0, avs_write = 0;
	logic [1:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata;
	logic [7:0] flags, alu_result, exp_f, exp_r, rd;
	logic avs_waitrequest;
	alu_req_s alu_req;
	ctrl_evt_s ctrl_evt;
	int num_errors = 0, samples_checked = 0;
	always #12.5 clk = ~clk;
	cpu_core_model cpu_core_model_i (.clk(clk), .run(run), .alu_req(alu_req), .ctrl_evt(ctrl_evt));
	cpu_status_flags cpu_status_flags_i (.clk(clk), .sys_rst(sys_rst), .alu_req(alu_req),
		.ctrl_evt(ctrl_evt), .flags(flags), .alu_result(alu_result), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	// reference model, one step per edge
	function automatic logic [7:0] nxt(input logic [7:0] f, input alu_req_s q,
		inout logic [7:0] rr);
		int b = (q.op == OP_ADD) ? q.b : 255 - q.b;
		int c = (q.op == OP_SUB) ? 1 : (q.op == OP_SUB_BORROW) ? q.carry_in : 0;
		int s = q.a + b + c;
		int r = (q.op == OP_LOGIC) ? q.a & q.b : s % 256;
		if (avs_write && avs_waitrequest === 1'b0 && avs_address == FLAGS_ADDR)
			f = (f & ~SW_WRITE_MASK) | (avs_writedata[7:0] & SW_WRITE_MASK);
		if (q.valid && q.op != OP_NONE) begin
			f[3] = q.op != OP_LOGIC && (q.a % 128 + b % 128 + c) / 128 != s / 256;
			if (q.op != OP_LOGIC) f[1] = (q.a % 16 + b % 16 + c) / 16;
			f[2] = r == 0;
			rr = r[7:0];
			f[7] = f[3] ^ (r / 128);
			if (q.op == OP_SUB) f[6] = f[2];
			if (q.op == OP_SUB_BORROW) f[6] = f[6] & f[2];
		end
		if (ctrl_evt.watchdog_clear_instr) f[5:4] = 2'h0;
		if (ctrl_evt.halt_instr) f[5:4] = 2'h1;
		if (ctrl_evt.wdt_expire) f[5] = 1;
		return f;
	endfunction : nxt
	always @(posedge clk) begin
		if (sys_rst) begin
			exp_f = FLAGS_RESET;
			exp_r = 8'h00;
		end else begin
			exp_f = nxt(exp_f, alu_req, exp_r);
		end
	end
	// compare every settled cycle, carry bit excluded
	always @(negedge clk) begin
		if (!sys_rst) begin
			chk("flags", exp_f & 8'hFE, flags & 8'hFE);
			chk("alu_result", exp_r, alu_result);
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one avalon-mm access, held until waitrequest is low
	task automatic bus(input logic w, input logic [1:0] ad, input logic [7:0] wd);
		int n = 0;
		logic late;
		avs_write <= w;
		avs_read <= !w;
		avs_address <= ad;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		late = avs_waitrequest !== 1'b0;
		rd = avs_readdata[7:0];
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk);
		if (late) begin
			num_errors++;
			tally_and_finish();
		end
	endtask : bus
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// reset, random traffic, register access, mid-run reset
	initial begin
		void'($urandom(32'hAF3D));
		repeat (12) @(posedge clk);
		sys_rst <= 0;
		run <= 1;
		repeat (3000) @(posedge clk);
		run <= 0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			bus(1, FLAGS_ADDR, 8'($urandom));
			bus(0, FLAGS_ADDR, 0);
			chk("rd_flags", exp_f & 8'hFE, rd & 8'hFE);
		end
		bus(1, ALU_RES_ADDR, 8'hFF);
		bus(0, ALU_RES_ADDR, 0);
		chk("rd_alu", exp_r, rd);
		bus(0, 2'h2, 0);
		chk("rd_unmapped", UNMAPPED_READ, rd);
		sys_rst <= 1;
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		run <= 1;
		repeat (500) @(posedge clk);
		tally_and_finish();
	end
endmodule : cpu_status_flags_tb
